// ### rtl/gp_port_pkg.sv
package gp_port_pkg;
    // ==========================================
    // Address map
    localparam logic [31:0] SUBSYS_RESET_OFFSET = 32'h0000_0000;
    localparam logic [31:0] GP_BYTE_OFFSET = 32'h0000_0003;
    localparam logic [31:0] ANALYSE_OFFSET = 32'h0000_0004;
    localparam int ADDR_TOP_BIT = 31;
    localparam int WORD_IDX_LO = 2;
    localparam int WORD_IDX_HI = 4;
    localparam logic [2:0] SUBSYS_RESET_IDX = 3'h0;
    localparam logic [2:0] ANALYSE_IDX = 3'h1;

    // ==========================================
    // Byte lanes and field positions
    localparam int GP_LANE = 3;
    localparam int LED_LANE = 0;
    localparam int ERR_BIT = 0;
    localparam int LED_RESET_BIT = 0;
    localparam int LED_ANALYSE_BIT = 1;
    localparam int LED_TWO_BIT = 2;

    // ==========================================
    // Power-up values
    localparam logic [7:0] GP_RESET = 8'h00;
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// ### rtl/programmed_io_byte_port.sv
module programmed_io_byte_port
    import gp_port_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic bus_req_i,
    input wire logic bus_wr_i,
    input wire logic [31:0] bus_addr_i,
    input wire logic [3:0] bus_be_i,
    input wire logic [31:0] bus_wdata_i,
    output logic [31:0] bus_rdata_o,
    output logic bus_ack_o,
    input wire logic subsystem_error_n_i,
    input wire logic ss_services_connected_i,
    output logic [7:0] general_purpose_lines_o,
    output logic led_line_two_o,
    output logic port_error_n_o,
    output logic subsystem_reset_n_o,
    output logic subsystem_analyse_ctl_n_o
);
    import gp_port_pkg::*;

    // ==========================================
    // Pin synchronisers
    logic err_n_meta_reg;
    logic err_n_sync_reg;
    logic conn_meta_reg;
    logic conn_sync_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            err_n_meta_reg <= 1'b1;
            err_n_sync_reg <= 1'b1;
            conn_meta_reg <= 1'b0;
            conn_sync_reg <= 1'b0;
        end
        else
        begin
            err_n_meta_reg <= subsystem_error_n_i;
            err_n_sync_reg <= err_n_meta_reg;
            conn_meta_reg <= ss_services_connected_i;
            conn_sync_reg <= conn_meta_reg;
        end
    end

    // ==========================================
    // Register file
    function automatic logic [7:0] lane_of(input logic [31:0] word, input int lane);
        lane_of = word[lane*8 +: 8];
    endfunction

    logic [7:0] gp_reg;
    logic [7:0] gp_next;
    logic [7:0] led_reg;
    logic [7:0] led_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ack_reg;
    logic ack_next;
    logic port_err_n_reg;
    logic port_err_n_next;
    logic hit;
    logic [2:0] word_idx;

    assign hit = bus_req_i && !bus_addr_i[ADDR_TOP_BIT];
    assign word_idx = bus_addr_i[WORD_IDX_HI:WORD_IDX_LO];

    always_comb
    begin
        gp_next = gp_reg;
        led_next = led_reg;
        rdata_next = rdata_reg;
        ack_next = bus_req_i;
        port_err_n_next = conn_sync_reg ? 1'b1 : err_n_sync_reg;
        if (hit && bus_wr_i)
        begin
            if (bus_be_i[GP_LANE])
            begin
                gp_next = lane_of(bus_wdata_i, GP_LANE);
            end
            if (bus_be_i[LED_LANE])
            begin
                led_next[word_idx] = bus_wdata_i[0];
            end
        end
        if (bus_req_i && !bus_wr_i)
        begin
            rdata_next = RDATA_RESET;
            if (hit)
            begin
                rdata_next[GP_LANE*8 +: 8] = gp_reg;
                if (word_idx == SUBSYS_RESET_IDX)
                begin
                    rdata_next[ERR_BIT] = !err_n_sync_reg;
                end
            end
        end
    end

    // Power-up reset only: no processor reset reaches these flops
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            gp_reg <= GP_RESET;
            led_reg <= LED_RESET;
            rdata_reg <= RDATA_RESET;
            ack_reg <= 1'b0;
            port_err_n_reg <= 1'b1;
        end
        else
        begin
            gp_reg <= gp_next;
            led_reg <= led_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            port_err_n_reg <= port_err_n_next;
        end
    end

    // ==========================================
    // Outputs
    assign bus_rdata_o = rdata_reg;
    assign bus_ack_o = ack_reg;
    assign general_purpose_lines_o = gp_reg;
    assign led_line_two_o = led_reg[LED_TWO_BIT];
    assign port_error_n_o = port_err_n_reg;
    assign subsystem_reset_n_o = !led_reg[LED_RESET_BIT];
    assign subsystem_analyse_ctl_n_o = !led_reg[LED_ANALYSE_BIT];

    // ==========================================
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    logic gp_wr;
    logic led_wr;
    assign gp_wr = hit && bus_wr_i && bus_be_i[GP_LANE];
    assign led_wr = hit && bus_wr_i && bus_be_i[LED_LANE];

    property p_gp_write;
        gp_wr |=> general_purpose_lines_o == $past(bus_wdata_i[31:24]);
    endproperty
    a_gp_write: assert property (p_gp_write) else $error("gp byte not stored");

    property p_bit_order;
        gp_wr |=> general_purpose_lines_o[0] == $past(bus_wdata_i[24])
            && general_purpose_lines_o[7] == $past(bus_wdata_i[31]);
    endproperty
    a_bit_order: assert property (p_bit_order) else $error("gp bit order wrong");

    property p_gp_hold;
        !gp_wr |=> $stable(general_purpose_lines_o);
    endproperty
    a_gp_hold: assert property (p_gp_hold) else $error("gp lines moved");

    property p_err_hidden;
        conn_sync_reg |=> port_error_n_o;
    endproperty
    a_err_hidden: assert property (p_err_hidden) else $error("error offered");

    property p_high_addr;
        bus_req_i && bus_addr_i[ADDR_TOP_BIT] |=> $stable(gp_reg) && $stable(led_reg);
    endproperty
    a_high_addr: assert property (p_high_addr) else $error("bit31 access wrote");

    property p_subsys_reset;
        led_wr && word_idx == SUBSYS_RESET_IDX |=> subsystem_reset_n_o == !$past(bus_wdata_i[0]);
    endproperty
    a_subsys_reset: assert property (p_subsys_reset) else $error("subsystem reset wrong");

    property p_analyse;
        led_wr && word_idx == ANALYSE_IDX
            |=> subsystem_analyse_ctl_n_o == !$past(bus_wdata_i[0]) && $stable(subsystem_reset_n_o);
    endproperty
    a_analyse: assert property (p_analyse) else $error("analyse wrong");

    property p_err_read;
        hit && !bus_wr_i && word_idx == SUBSYS_RESET_IDX
            |=> bus_ack_o && bus_rdata_o[0] == !$past(err_n_sync_reg);
    endproperty
    a_err_read: assert property (p_err_read) else $error("error bit wrong");

    property p_lane_only;
        hit && bus_wr_i && !bus_be_i[GP_LANE] ##1 !gp_wr |-> $stable(general_purpose_lines_o);
    endproperty
    a_lane_only: assert property (p_lane_only) else $error("unselected lane hit");

    property p_gp_read;
        hit && !bus_wr_i |=> bus_rdata_o[31:24] == $past(gp_reg);
    endproperty
    a_gp_read: assert property (p_gp_read) else $error("gp readback wrong");

    property p_led_two;
        led_wr && word_idx == 3'(LED_TWO_BIT) |=> led_line_two_o == $past(bus_wdata_i[0]);
    endproperty
    a_led_two: assert property (p_led_two) else $error("led line two wrong");

    // Error pin is passed through unchanged in level while no services link is attached
    property p_err_port;
        !conn_sync_reg |=> port_error_n_o == $past(err_n_sync_reg);
    endproperty
    a_err_port: assert property (p_err_port) else $error("port error not passed");

    c_gp_write: cover property (gp_wr ##1 general_purpose_lines_o != GP_RESET);
    c_reset_pulse: cover property (!subsystem_reset_n_o ##[1:20] subsystem_reset_n_o);
    c_err_read: cover property (hit && !bus_wr_i ##1 bus_rdata_o[0]);
    c_analyse: cover property (led_wr && word_idx == ANALYSE_IDX ##1 !subsystem_analyse_ctl_n_o);
    c_err_hidden: cover property (conn_sync_reg && !err_n_sync_reg ##1 port_error_n_o);
endmodule

// ### tb/host_bus_model.sv
// ==========================================
// Host processor memory bus master
module host_bus_model
(
    input wire logic mclk_i,
    input wire logic ack_i,
    output logic req_o,
    output logic wr_o,
    output logic [31:0] addr_o,
    output logic [3:0] be_o,
    output logic [31:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        req_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 32'h0;
        be_o = 4'h0;
        wdata_o = 32'h0;
    end

    // One request cycle, then wait up to three cycles for the single ack; gap models a slow host
    task automatic access(input logic wr, input logic [31:0] addr, input logic [3:0] be,
        input logic [31:0] wd, input int gap);
        int n;
        begin
            repeat (gap) @(negedge mclk_i);
            @(negedge mclk_i);
            req_o = 1'b1;
            wr_o = wr;
            addr_o = addr;
            be_o = be;
            wdata_o = wd;
            @(negedge mclk_i);
            // Released address, data and byte-enable lines show garbage; wr keeps its last value
            req_o = 1'b0;
            addr_o = ~addr;
            wdata_o = ~wd;
            be_o = ~be;
            n = 0;
            while (ack_i !== 1'b1 && n < 3)
            begin
                @(negedge mclk_i);
                n++;
            end
        end
    endtask
endmodule

// ### tb/programmed_io_byte_port_tb_top.sv
module programmed_io_byte_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gp_port_pkg::*;

    logic mclk_i, rst_n_i, req, wr, ack, err_n, conn, led2, perr_n, ssr_n, ssa_n;
    logic [31:0] addr, wdata, rdata, a;
    logic [3:0] be;
    logic [7:0] gp, gp_exp;
    logic [32:0] note;
    logic [32:0] notes[$];
    logic [31:0] seed = 32'h02e75697;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    programmed_io_byte_port DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_req_i(req),
        .bus_wr_i(wr), .bus_addr_i(addr), .bus_be_i(be), .bus_wdata_i(wdata),
        .bus_rdata_o(rdata), .bus_ack_o(ack), .subsystem_error_n_i(err_n),
        .ss_services_connected_i(conn), .general_purpose_lines_o(gp),
        .led_line_two_o(led2), .port_error_n_o(perr_n), .subsystem_reset_n_o(ssr_n),
        .subsystem_analyse_ctl_n_o(ssa_n));

    host_bus_model host (.mclk_i(mclk_i), .ack_i(ack), .req_o(req), .wr_o(wr),
        .addr_o(addr), .be_o(be), .wdata_o(wdata));

    // ==========================================
    // Checking and closing
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic acc(input logic w, input logic [31:0] ad, input logic [3:0] b,
        input logic [31:0] wd, input logic [31:0] exp);
        notes.push_back({~w, exp});
        host.access(w, ad, b, wd, int'(seed[1:0]));
    endtask

    // Every ack consumes the oldest note; an extra ack finds none
    always @(negedge mclk_i)
    begin
        if (ack === 1'b1)
        begin
            if (notes.size() == 0)
                check("spare ack", 32'h0, 32'h1);
            else
            begin
                note = notes.pop_front();
                if (note[32])
                    check("rdata", note[31:0], rdata);
            end
        end
    end

    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            test_done();
        end
    end

    // ==========================================
    // Main sequence
    initial
    begin
        err_n = 1'b1;
        conn = 1'b0;
        rst_n_i = 1'b0;
        repeat (5) @(posedge mclk_i);
        @(negedge mclk_i) rst_n_i = 1'b1;
        check("gp reset", 32'h0, {24'h0, gp});
        check("ctl reset", 32'h3, {29'h0, led2, ssa_n, ssr_n});
        for (int i = 0; i < 8; i++)
        begin
            gp_exp = 8'($random(seed));
            a = {1'b0, 29'($random(seed)), 2'b11};
            acc(1'b1, a, 4'h8, {gp_exp, 24'($random(seed))}, 32'h0);
            check("gp pins", {24'h0, gp_exp}, {24'h0, gp});
            acc(1'b0, {a[31:2], 2'b00}, 4'h0, 32'h0, {gp_exp, 24'h0});
        end
        acc(1'b1, 32'h8000_0003, 4'h8, ~{gp_exp, 24'h0}, 32'h0);
        acc(1'b0, 32'h8000_0000, 4'h0, 32'h0, 32'h0);
        check("gp unmapped", {24'h0, gp_exp}, {24'h0, gp});
        for (int i = 0; i < 3; i++)
        begin
            acc(1'b1, 32'(i * 4), 4'h1, 32'hff00_0001, 32'h0);
            check("ctl set", 32'(3'b011 ^ (3'b001 << i)), {29'h0, led2, ssa_n, ssr_n});
            check("gp kept", {24'h0, gp_exp}, {24'h0, gp});
            acc(1'b1, 32'(i * 4 + 32), 4'h1, 32'h0, 32'h0);
            check("ctl clear", 32'h3, {29'h0, led2, ssa_n, ssr_n});
        end
        acc(1'b1, 32'h0, 4'hf, 32'ha500_0001, 32'h0);
        check("word write", 32'ha5_0, {20'h0, gp, 3'h0, ssr_n});
        acc(1'b1, 32'h0, 4'h1, 32'h0, 32'h0);
        @(negedge mclk_i) err_n = 1'b0;
        repeat (4) @(negedge mclk_i);
        check("port error", 32'h0, {31'h0, perr_n});
        acc(1'b0, 32'h0, 4'h0, 32'h0, 32'ha500_0001);
        acc(1'b0, 32'h4, 4'h0, 32'h0, 32'ha500_0000);
        @(negedge mclk_i) conn = 1'b1;
        repeat (4) @(negedge mclk_i);
        check("port error hidden", 32'h1, {31'h0, perr_n});
        rst_n_i = 1'b0;
        @(negedge mclk_i) rst_n_i = 1'b1;
        check("gp power-up", 32'h0, {24'h0, gp});
        repeat (2) @(negedge mclk_i);
        // A lost ack leaves its note behind
        check("notes left", 32'h0, 32'(notes.size()));
        test_done();
    end
endmodule
